/* File: design/fpoi_front_panel.sv */
// Front panel operator interface: keys, two displays, eight LEDs and an APB register file.
// ==========================================
// How it works
// - Two four-digit displays, three keys, eight LEDs.
// - Display content chosen by current panel mode.
// - Output LEDs follow their control outputs, except both dark when both are set in the three-step variant.
// - Setpoint LED lit during manual setpoint adjust.
// - Loop fault LED blinks during loop break.
// - Halt LED steady on operator stop.
// - Halt LED blinks on automatic stop.
// - Hand mode LED lit during manual control.
// - Up increments value or moves menu.
// - Down decrements value or moves menu.
// - Config key over 3 s enters/leaves.
// - Config key under 1 s opens/stores-advances.
// - Inputs taken continuously through processing chain.
// - Calculator gives sum, ratio, difference, root.
// - Selector picks signal feeding control and alarm.
// - Menu holds seven parameter groups.
// - Start-up shows the operation group.
// - Analog-plus-alarm or three-step output variant.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`include "fpoi_map.svh"

module fpoi_front_panel #(
	parameter int unsigned LONG_CYCLES = `FPOI_MS_TO_CYC(`FPOI_LONG_MS),
	parameter int unsigned SHORT_CYCLES = `FPOI_MS_TO_CYC(`FPOI_SHORT_MS),
	parameter int unsigned DEBOUNCE_CYCLES = `FPOI_MS_TO_CYC(`FPOI_DEBOUNCE_MS),
	parameter int unsigned BLINK_CYCLES = `FPOI_MS_TO_CYC(`FPOI_BLINK_MS),
	parameter int unsigned FLASH_CYCLES = `FPOI_MS_TO_CYC(`FPOI_FLASH_MS)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic keyUpN,
	input wire logic keyDownN,
	input wire logic configKeyN,
	output logic [15:0] upperDisp,
	output logic [15:0] lowerDisp,
	output logic firstOutputLed,
	output logic secondOutputLed,
	output logic setpointLed,
	output logic loopFaultLed,
	output logic haltLed,
	output logic tuneLed,
	output logic linkActivityLed,
	output logic handModeLed
);

	// ==========================================
	// Reset release
	logic rstSync1_r, rstSync2_r, rstN;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end
	assign rstN = rstSync2_r;

	// ==========================================
	// Key synchronisers and debounce
	logic [2:0] keyPinN, keyHeld, keyPrev_r, keyPressEv, keyRelEv;
	assign keyPinN = {configKeyN, keyDownN, keyUpN};
	for (genvar i = 0; i < 3; i++) begin : gKey
		logic s1_r, s2_r, s3_r, held_r;
		logic [31:0] cnt_r;
		always_ff @(posedge clk or negedge rstN) begin
			if (!rstN) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
				s3_r <= 1'b0;
				held_r <= 1'b0;
				cnt_r <= '0;
			end else begin
				s1_r <= ~keyPinN[i];
				s2_r <= s1_r;
				s3_r <= s2_r;
				if (s2_r != s3_r || s3_r == held_r) begin
					cnt_r <= '0;
				end else if (cnt_r >= DEBOUNCE_CYCLES - 1) begin
					held_r <= s3_r;
					cnt_r <= '0;
				end else begin
					cnt_r <= cnt_r + 32'h1;
				end
			end
		end
		assign keyHeld[i] = held_r;
	end
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			keyPrev_r <= 3'h0;
		end else begin
			keyPrev_r <= keyHeld;
		end
	end
	assign keyPressEv = keyHeld & ~keyPrev_r;
	assign keyRelEv = ~keyHeld & keyPrev_r;

	// ==========================================
	// Press duration of the configuration key
	// Up and down are ignored while the configuration key is held, and a configuration key
	// press together with another key counts as a combination, which is not acted on here.
	logic [31:0] holdCnt_r;
	logic comboSeen_r, upEv, downEv, longEv, shortEv;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			holdCnt_r <= '0;
			comboSeen_r <= 1'b0;
		end else if (keyHeld[2]) begin
			if (holdCnt_r < LONG_CYCLES) begin
				holdCnt_r <= holdCnt_r + 32'h1;
			end
			if (keyHeld[1] || keyHeld[0]) begin
				comboSeen_r <= 1'b1;
			end
		end else begin
			holdCnt_r <= '0;
			comboSeen_r <= 1'b0;
		end
	end
	assign longEv = keyHeld[2] && !comboSeen_r && holdCnt_r == LONG_CYCLES - 1;
	assign shortEv = keyRelEv[2] && !comboSeen_r && holdCnt_r < SHORT_CYCLES;
	assign upEv = keyPressEv[0] && !keyHeld[2];
	assign downEv = keyPressEv[1] && !keyHeld[2];

	// ==========================================
	// APB register file
	logic [`FPOI_CTRL_W-1:0] ctrl_r;
	logic [`FPOI_SEL_W-1:0] sel_r;
	logic [15:0] pv1_r, pv2_r, errCode_r, setpoint_r, editVal_r, calcRes_r, feed_r;
	logic [5:0] pAddr_r;
	logic [15:0] paramMem [0:`FPOI_PARAM_WORDS-1];
	logic apbSetup, apbWr, mapped, actEv, calcBusy;
	logic [31:0] readMux;
	fpoi_pkg::fpoi_mode_t mode_r;
	logic [2:0] group_r, paramIdx_r;

	assign apbSetup = psel && !penable;
	assign apbWr = psel && penable && pwrite && pready;
	assign actEv = apbWr && paddr == `FPOI_REG_ACTIVITY;

	always_comb begin
		mapped = 1'b1;
		readMux = 32'h0;
		unique case (paddr)
			`FPOI_REG_CTRL: readMux = {21'h0, ctrl_r};
			`FPOI_REG_PV1: readMux = {16'h0, pv1_r};
			`FPOI_REG_PV2: readMux = {16'h0, pv2_r};
			`FPOI_REG_SETPOINT: readMux = {16'h0, setpoint_r};
			`FPOI_REG_SELECT: readMux = {27'h0, sel_r};
			`FPOI_REG_FEED: readMux = {16'h0, feed_r};
			`FPOI_REG_STATUS: readMux = {20'h0, calcBusy, keyHeld, paramIdx_r, group_r, mode_r};
			`FPOI_REG_ERRCODE: readMux = {16'h0, errCode_r};
			`FPOI_REG_PADDR: readMux = {26'h0, pAddr_r};
			`FPOI_REG_PDATA: readMux = (pAddr_r < 6'(`FPOI_PARAM_WORDS)) ?
				{16'h0, paramMem[pAddr_r]} : 32'h0;
			`FPOI_REG_ACTIVITY: readMux = 32'h0;
			default: mapped = 1'b0;
		endcase
	end

	// Answer one cycle after setup: the access phase always ends at its first edge.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= apbSetup;
			if (apbSetup) begin
				prdata <= pwrite ? 32'h0 : readMux;
				pslverr <= !mapped;
			end
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ctrl_r <= `FPOI_CTRL_RESET;
			sel_r <= `FPOI_SEL_RESET;
			pv1_r <= 16'h0;
			pv2_r <= 16'h0;
			errCode_r <= 16'h0;
			pAddr_r <= 6'h0;
		end else if (apbWr) begin
			unique case (paddr)
				`FPOI_REG_CTRL: ctrl_r <= pwdata[`FPOI_CTRL_W-1:0];
				`FPOI_REG_PV1: pv1_r <= pwdata[15:0];
				`FPOI_REG_PV2: pv2_r <= pwdata[15:0];
				`FPOI_REG_SELECT: sel_r <= pwdata[`FPOI_SEL_W-1:0];
				`FPOI_REG_ERRCODE: errCode_r <= pwdata[15:0];
				`FPOI_REG_PADDR: pAddr_r <= pwdata[5:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// Panel mode, group and parameter navigation
	logic storeEv;
	logic [2:0] nextIdx;
	assign storeEv = mode_r == fpoi_pkg::MODE_EDIT && shortEv;
	assign nextIdx = paramIdx_r + 3'h1;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			mode_r <= fpoi_pkg::MODE_OPER;
			group_r <= 3'h0;
			paramIdx_r <= 3'h0;
			editVal_r <= 16'h0;
		end else begin
			unique case (mode_r)
				fpoi_pkg::MODE_OPER: begin
					if (longEv) begin
						mode_r <= fpoi_pkg::MODE_MENU;
						group_r <= 3'h0;
					end
				end
				fpoi_pkg::MODE_MENU: begin
					if (longEv) begin
						mode_r <= fpoi_pkg::MODE_OPER;
						group_r <= 3'h0;
					end else if (shortEv) begin
						mode_r <= fpoi_pkg::MODE_EDIT;
						paramIdx_r <= 3'h0;
						editVal_r <= paramMem[{group_r, 3'h0}];
					end else if (upEv) begin
						group_r <= (group_r == `FPOI_GROUP_LAST) ? 3'h0 : group_r + 3'h1;
					end else if (downEv) begin
						group_r <= (group_r == 3'h0) ? `FPOI_GROUP_LAST : group_r - 3'h1;
					end
				end
				fpoi_pkg::MODE_EDIT: begin
					if (longEv) begin
						mode_r <= fpoi_pkg::MODE_MENU;
					end else if (shortEv) begin
						paramIdx_r <= nextIdx;
						editVal_r <= paramMem[{group_r, nextIdx}];
					end else if (upEv) begin
						editVal_r <= editVal_r + 16'h1;
					end else if (downEv) begin
						editVal_r <= editVal_r - 16'h1;
					end
				end
			endcase
		end
	end

	// Stored parameters survive until reset; a key store wins over a bus write in the same cycle.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			for (int w = 0; w < `FPOI_PARAM_WORDS; w++) begin
				paramMem[w] <= 16'h0;
			end
		end else if (storeEv) begin
			paramMem[{group_r, paramIdx_r}] <= editVal_r;
		end else if (apbWr && paddr == `FPOI_REG_PDATA && pAddr_r < 6'(`FPOI_PARAM_WORDS)) begin
			paramMem[pAddr_r] <= pwdata[15:0];
		end
	end

	// Setpoint keys act only in operation mode with manual setpoint adjustment enabled.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			setpoint_r <= `FPOI_SETPOINT_RESET;
		end else if (apbWr && paddr == `FPOI_REG_SETPOINT) begin
			setpoint_r <= pwdata[15:0];
		end else if (mode_r == fpoi_pkg::MODE_OPER && ctrl_r[`FPOI_CTRL_SPMAN]) begin
			if (upEv) begin
				setpoint_r <= setpoint_r + 16'h1;
			end else if (downEv) begin
				setpoint_r <= setpoint_r - 16'h1;
			end
		end
	end

	// ==========================================
	// Two-input calculator and input selector
	// Ratio and root run as bit-serial loops to save area; the result lags by up to 26 cycles.
	fpoi_pkg::fpoi_calc_st_t cst_r;
	fpoi_pkg::fpoi_calc_fn_t fnRun_r, fnSel;
	logic [23:0] quo_r;
	logic [15:0] rem_r, den_r, root_r, one_r;
	logic [4:0] iter_r;
	logic [16:0] sum17, remShift, rootTry;
	assign fnSel = fpoi_pkg::fpoi_calc_fn_t'(sel_r[`FPOI_SEL_CALC_MSB:`FPOI_SEL_CALC_LSB]);
	assign sum17 = {1'b0, pv1_r} + {1'b0, pv2_r};
	assign remShift = {rem_r, quo_r[23]};
	assign rootTry = {1'b0, root_r} + {1'b0, one_r};
	assign calcBusy = cst_r != fpoi_pkg::CST_IDLE;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cst_r <= fpoi_pkg::CST_IDLE;
			fnRun_r <= fpoi_pkg::CALC_SUM;
			quo_r <= 24'h0;
			rem_r <= 16'h0;
			den_r <= 16'h0;
			root_r <= 16'h0;
			one_r <= 16'h0;
			iter_r <= 5'h0;
			calcRes_r <= 16'h0;
		end else begin
			unique case (cst_r)
				fpoi_pkg::CST_IDLE: begin
					fnRun_r <= fnSel;
					unique case (fnSel)
						fpoi_pkg::CALC_SUM: calcRes_r <= sum17[16] ? 16'hFFFF : sum17[15:0];
						fpoi_pkg::CALC_DIFF: calcRes_r <= (pv1_r >= pv2_r) ? pv1_r - pv2_r : 16'h0;
						fpoi_pkg::CALC_RATIO: begin
							quo_r <= {pv1_r, 8'h00};
							den_r <= pv2_r;
							rem_r <= 16'h0;
							iter_r <= 5'h0;
							cst_r <= fpoi_pkg::CST_DIV;
						end
						fpoi_pkg::CALC_ROOTDIFF: begin
							rem_r <= (pv1_r >= pv2_r) ? pv1_r - pv2_r : 16'h0;
							root_r <= 16'h0;
							one_r <= `FPOI_ROOT_START;
							cst_r <= fpoi_pkg::CST_ROOT;
						end
					endcase
				end
				fpoi_pkg::CST_DIV: begin
					if (remShift >= {1'b0, den_r}) begin
						rem_r <= 16'(remShift - {1'b0, den_r});
						quo_r <= {quo_r[22:0], 1'b1};
					end else begin
						rem_r <= remShift[15:0];
						quo_r <= {quo_r[22:0], 1'b0};
					end
					iter_r <= iter_r + 5'h1;
					if (iter_r == 5'h17) begin
						cst_r <= fpoi_pkg::CST_DONE;
					end
				end
				fpoi_pkg::CST_ROOT: begin
					if ({1'b0, rem_r} >= rootTry) begin
						rem_r <= 16'({1'b0, rem_r} - rootTry);
						root_r <= (root_r >> 1) + one_r;
					end else begin
						root_r <= root_r >> 1;
					end
					one_r <= one_r >> 2;
					if (one_r == 16'h1) begin
						cst_r <= fpoi_pkg::CST_DONE;
					end
				end
				fpoi_pkg::CST_DONE: begin
					if (fnRun_r == fpoi_pkg::CALC_RATIO) begin
						calcRes_r <= (den_r == 16'h0 || quo_r[23:16] != 8'h0) ? 16'hFFFF : quo_r[15:0];
					end else begin
						calcRes_r <= root_r;
					end
					cst_r <= fpoi_pkg::CST_IDLE;
				end
			endcase
		end
	end

	// Without a measuring auxiliary input only the first input can feed control.
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			feed_r <= 16'h0;
		end else if (!sel_r[`FPOI_SEL_AUXMEAS]) begin
			feed_r <= pv1_r;
		end else begin
			unique case (sel_r[`FPOI_SEL_FEED_MSB:`FPOI_SEL_FEED_LSB])
				`FPOI_FEED_PV2: feed_r <= pv2_r;
				`FPOI_FEED_CALC: feed_r <= calcRes_r;
				default: feed_r <= pv1_r;
			endcase
		end
	end

	// ==========================================
	// Blink and flash timing
	logic [31:0] blinkCnt_r, flashCnt_r;
	logic blink_r;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			blinkCnt_r <= '0;
			blink_r <= 1'b0;
		end else if (blinkCnt_r >= BLINK_CYCLES - 1) begin
			blinkCnt_r <= '0;
			blink_r <= !blink_r;
		end else begin
			blinkCnt_r <= blinkCnt_r + 32'h1;
		end
	end
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			flashCnt_r <= '0;
		end else if (actEv) begin
			flashCnt_r <= FLASH_CYCLES;
		end else if (flashCnt_r != 32'h0) begin
			flashCnt_r <= flashCnt_r - 32'h1;
		end
	end

	// ==========================================
	// LEDs and displays
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			firstOutputLed <= 1'b0;
			secondOutputLed <= 1'b0;
			setpointLed <= 1'b0;
			loopFaultLed <= 1'b0;
			haltLed <= 1'b0;
			tuneLed <= 1'b0;
			linkActivityLed <= 1'b0;
			handModeLed <= 1'b0;
		end else begin
			// In the three-step variant open and close together is illegal, so both stay dark.
			if (ctrl_r[`FPOI_CTRL_THREESTEP] && ctrl_r[`FPOI_CTRL_FIRST_OUTPUT_LED] && ctrl_r[`FPOI_CTRL_SECOND_OUTPUT_LED]) begin
				firstOutputLed <= 1'b0;
				secondOutputLed <= 1'b0;
			end else begin
				firstOutputLed <= ctrl_r[`FPOI_CTRL_FIRST_OUTPUT_LED];
				secondOutputLed <= ctrl_r[`FPOI_CTRL_SECOND_OUTPUT_LED];
			end
			setpointLed <= ctrl_r[`FPOI_CTRL_SPMAN];
			loopFaultLed <= ctrl_r[`FPOI_CTRL_LOOPFAULT] && blink_r;
			if (ctrl_r[`FPOI_CTRL_AUTOSTOP]) begin
				haltLed <= blink_r;
			end else begin
				haltLed <= ctrl_r[`FPOI_CTRL_USERSTOP];
			end
			tuneLed <= ctrl_r[`FPOI_CTRL_TUNEFAIL] ? blink_r : ctrl_r[`FPOI_CTRL_TUNERUN];
			linkActivityLed <= flashCnt_r != 32'h0;
			handModeLed <= ctrl_r[`FPOI_CTRL_HAND];
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			upperDisp <= 16'h0;
			lowerDisp <= 16'h0;
		end else begin
			unique case (mode_r)
				fpoi_pkg::MODE_OPER: begin
					upperDisp <= feed_r;
					lowerDisp <= setpoint_r;
				end
				fpoi_pkg::MODE_MENU: begin
					upperDisp <= `FPOI_MENU_CODE;
					lowerDisp <= {13'h0, group_r};
				end
				fpoi_pkg::MODE_EDIT: begin
					upperDisp <= {`FPOI_NAME_TAG, 1'b0, group_r, 1'b0, paramIdx_r};
					lowerDisp <= editVal_r;
				end
			endcase
			if (ctrl_r[`FPOI_CTRL_ERROR]) begin
				upperDisp <= errCode_r;
			end
		end
	end

endmodule

/* File: pkg/fpoi_map.svh */
// Register offsets, field positions, reset values and timing counts of the front panel.
`ifndef FPOI_MAP_SVH
`define FPOI_MAP_SVH

// ==========================================
// Timing
`define FPOI_CLK_HZ 20000000
`define FPOI_LONG_MS 3000
`define FPOI_SHORT_MS 1000
`define FPOI_DEBOUNCE_MS 20
`define FPOI_BLINK_MS 500
`define FPOI_FLASH_MS 100
`define FPOI_MS_TO_CYC(ms) ((`FPOI_CLK_HZ / 1000) * (ms))

// ==========================================
// Register byte offsets
`define FPOI_REG_CTRL 8'h00
`define FPOI_REG_PV1 8'h04
`define FPOI_REG_PV2 8'h08
`define FPOI_REG_SETPOINT 8'h0C
`define FPOI_REG_SELECT 8'h10
`define FPOI_REG_FEED 8'h14
`define FPOI_REG_STATUS 8'h18
`define FPOI_REG_ERRCODE 8'h1C
`define FPOI_REG_PADDR 8'h20
`define FPOI_REG_PDATA 8'h24
`define FPOI_REG_ACTIVITY 8'h28

// ==========================================
// Control register fields
`define FPOI_CTRL_FIRST_OUTPUT_LED 0
`define FPOI_CTRL_SECOND_OUTPUT_LED 1
`define FPOI_CTRL_SPMAN 2
`define FPOI_CTRL_LOOPFAULT 3
`define FPOI_CTRL_USERSTOP 4
`define FPOI_CTRL_AUTOSTOP 5
`define FPOI_CTRL_HAND 6
`define FPOI_CTRL_TUNERUN 7
`define FPOI_CTRL_TUNEFAIL 8
`define FPOI_CTRL_ERROR 9
`define FPOI_CTRL_THREESTEP 10
`define FPOI_CTRL_W 11
`define FPOI_CTRL_RESET 11'h000

// ==========================================
// Select register fields
`define FPOI_SEL_FEED_LSB 0
`define FPOI_SEL_FEED_MSB 1
`define FPOI_SEL_CALC_LSB 2
`define FPOI_SEL_CALC_MSB 3
`define FPOI_SEL_AUXMEAS 4
`define FPOI_SEL_W 5
`define FPOI_SEL_RESET 5'h00
`define FPOI_FEED_PV1 2'h0
`define FPOI_FEED_PV2 2'h1
`define FPOI_FEED_CALC 2'h2

// ==========================================
// Menu layout and display codes
`define FPOI_GROUP_COUNT 3'h7
`define FPOI_GROUP_LAST 3'h6
`define FPOI_PARAM_WORDS 56
`define FPOI_MENU_CODE 16'hAE5C
`define FPOI_NAME_TAG 8'hC0
`define FPOI_SETPOINT_RESET 16'h0000
`define FPOI_ROOT_START 16'h4000

`endif

/* File: pkg/fpoi_pkg.sv */
// Types used by the front panel design; its bench does not import them.
package fpoi_pkg;

	// ==========================================
	// Panel modes and calculator
	typedef enum logic [1:0] {MODE_OPER, MODE_MENU, MODE_EDIT} fpoi_mode_t;
	typedef enum logic [1:0] {CALC_SUM, CALC_RATIO, CALC_DIFF, CALC_ROOTDIFF} fpoi_calc_fn_t;
	typedef enum logic [1:0] {CST_IDLE, CST_DIV, CST_ROOT, CST_DONE} fpoi_calc_st_t;

endpackage

/* File: tb/fpoi_front_panel_properties.sv */
// Checker of the front panel LEDs, menu display and bus answer timing.
`include "fpoi_map.svh"

module fpoi_panel_checker #(
	parameter int unsigned BLINK_CYCLES = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [15:0] upperDisp,
	input wire logic [15:0] lowerDisp,
	input wire logic firstOutputLed,
	input wire logic secondOutputLed,
	input wire logic setpointLed,
	input wire logic loopFaultLed,
	input wire logic haltLed,
	input wire logic handModeLed
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BLINK_WIN = 2 * BLINK_CYCLES + 8;
	logic ctlWr;
	logic [10:0] ctl_r;
	logic [1:0] settle_r;
	logic settled;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Shadow of the control word, settled three edges after each write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= 11'h000;
			settle_r <= 2'h0;
		end else if (ctlWr) begin
			ctl_r <= pwdata[10:0];
			settle_r <= 2'h0;
		end else if (settle_r != 2'h3) begin
			settle_r <= settle_r + 2'h1;
		end
	end
	assign settled = settle_r == 2'h3;
	assign ctlWr = psel && penable && pready && pwrite && paddr == `FPOI_REG_CTRL;
	// ==========================================
	// Assertions
	AST_APB_ANSWER: assert property (psel && !penable |=> pready)
		else $error("bus access not answered in one cycle");
	AST_FIRST_OUTPUT_LED_LED: assert property (settled |->
		firstOutputLed == (ctl_r[0] && !(ctl_r[10] && ctl_r[1])))
		else $error("first output LED wrong");
	AST_SECOND_OUTPUT_LED_LED: assert property (settled |->
		secondOutputLed == (ctl_r[1] && !(ctl_r[10] && ctl_r[0])))
		else $error("second output LED wrong");
	AST_SP_LED: assert property (settled |-> setpointLed == ctl_r[2])
		else $error("setpoint LED wrong");
	// A new control word may end the blink before the next toggle, so a write ends the wait.
	AST_LOOP_BLINK: assert property (settled && ctl_r[3] |->
		##[1:BLINK_WIN] ($changed(loopFaultLed) || !settled))
		else $error("loop fault LED not blinking");
	AST_HALT_STEADY: assert property (settled && !ctlWr && ctl_r[4] && !ctl_r[5] |->
		haltLed [*3])
		else $error("halt LED not steady");
	AST_HALT_BLINK: assert property (settled && ctl_r[5] |->
		##[1:BLINK_WIN] ($changed(haltLed) || !settled))
		else $error("halt LED not blinking");
	AST_HAND_LED: assert property (settled |-> handModeLed == ctl_r[6])
		else $error("hand mode LED wrong");
	AST_MENU_GROUP: assert property (upperDisp == `FPOI_MENU_CODE |-> lowerDisp < 16'h0007)
		else $error("menu shows a group out of range");
endmodule

bind fpoi_front_panel fpoi_panel_checker #(.BLINK_CYCLES(BLINK_CYCLES)) chk (
	.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .upperDisp(upperDisp),
	.lowerDisp(lowerDisp), .firstOutputLed(firstOutputLed), .secondOutputLed(secondOutputLed),
	.setpointLed(setpointLed), .loopFaultLed(loopFaultLed), .haltLed(haltLed),
	.handModeLed(handModeLed)
);

/* File: tb/fpoi_operator_model.sv */
// Operator model: presses keys for a commanded time, with contact chatter.
module fpoi_operator_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pressReq,
	input wire logic [2:0] pressKey,
	input wire logic [15:0] pressLen,
	output logic keyUpN,
	output logic keyDownN,
	output logic configKeyN,
	output logic pressBusy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] count_r;
	logic [2:0] held_r;
	logic chatter;
	logic [2:0] down;
	// ==========================================
	// Press timing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= 16'h0000;
			held_r <= 3'h0;
		end else if (pressReq && count_r == 16'h0000) begin
			count_r <= pressLen;
			held_r <= pressKey;
		end else if (count_r != 16'h0000) begin
			count_r <= count_r - 16'h0001;
		end
	end
	// Contacts chatter at both ends of a press, as real keys do; the pins are pulled up.
	always_comb begin
		chatter = (count_r > pressLen - 16'h0002) || (count_r < 16'h0003);
		down = (count_r != 16'h0000) ? held_r : 3'h0;
		if (chatter) begin
			down = down & {3{count_r[0]}};
		end
	end
	assign keyUpN = !down[0];
	assign keyDownN = !down[1];
	assign configKeyN = !down[2];
	assign pressBusy = count_r != 16'h0000;
endmodule

/* File: tb/front_panel_operator_interface_test.sv */
// Self-checking bench of the front panel with an operator model.
`include "fpoi_map.svh"

module front_panel_operator_interface_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pressReq, pressBusy;
	logic keyUpN, keyDownN, configKeyN;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] upperDisp, lowerDisp, pressLen;
	logic [2:0] pressKey;
	logic led1, led2, ledSp, ledLoop, ledHalt, ledHand, ledTune, ledLink;
	int fail_count = 0;
	int num_checks = 0;
	int seed = 46004;

	fpoi_front_panel #(.LONG_CYCLES(200), .SHORT_CYCLES(80), .DEBOUNCE_CYCLES(4),
		.BLINK_CYCLES(16), .FLASH_CYCLES(10)) uut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.keyUpN(keyUpN), .keyDownN(keyDownN), .configKeyN(configKeyN),
		.upperDisp(upperDisp), .lowerDisp(lowerDisp), .firstOutputLed(led1),
		.secondOutputLed(led2), .setpointLed(ledSp), .loopFaultLed(ledLoop),
		.haltLed(ledHalt), .tuneLed(ledTune), .linkActivityLed(ledLink), .handModeLed(ledHand)
	);
	fpoi_operator_model op (
		.clk(clk), .rst_n(rst_n), .pressReq(pressReq), .pressKey(pressKey),
		.pressLen(pressLen), .keyUpN(keyUpN), .keyDownN(keyDownN),
		.configKeyN(configKeyN), .pressBusy(pressBusy)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================
	// Tasks and reference functions
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Starts one edge late so back-to-back calls never drive psel twice in a time step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask

	task automatic press(input logic [2:0] k, input int len);
		@(posedge clk);
		pressKey <= k;
		pressLen <= 16'(len);
		pressReq <= 1'b1;
		@(posedge clk);
		pressReq <= 1'b0;
		@(posedge clk);
		while (pressBusy)
			@(posedge clk);
		repeat (30) @(posedge clk);
	endtask

	function automatic logic [15:0] calc_exp(logic [1:0] fn, logic [15:0] a, logic [15:0] b);
		logic [31:0] t;
		logic [15:0] r;
		t = (a > b) ? 32'(a - b) : 32'h0;
		case (fn)
			2'h0: t = 32'(a) + 32'(b);
			2'h1: t = (b == 16'h0) ? 32'hFFFF_FFFF : (32'(a) << 8) / 32'(b);
			2'h3: begin
				r = 16'h0;
				while ((32'(r) + 1) * (32'(r) + 1) <= t) r++;
				t = 32'(r);
			end
			default: t = t;
		endcase
		return (t > 32'hFFFF) ? 16'hFFFF : t[15:0];
	endfunction

	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		final_report();
	end

	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] q;
		logic e;
		logic [10:0] c;
		logic [15:0] a, b;
		logic [1:0] fn;
		logic last;
		int tg;
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{pressReq, pressKey, pressLen} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`FPOI_REG_STATUS, q);
		check(q & 32'h1F, 32'h0);
		rd(`FPOI_REG_CTRL, q);
		check(q, 32'h0);
		check(32'(lowerDisp), 32'h0);
		apb(1'b0, 8'h3C, 32'h0, q, e);
		check({q[30:0], e}, 32'h1);
		for (int i = 0; i < 12; i++) begin
			c = (i == 0) ? 11'h403 : (i == 1) ? 11'h038 : 11'($random(seed));
			wr(`FPOI_REG_CTRL, {21'h0, c});
			repeat (4) @(posedge clk);
			check(32'(led1), 32'(c[0] & !(c[10] & c[1])));
			check(32'(led2), 32'(c[1] & !(c[10] & c[0])));
			check(32'(ledSp), 32'(c[2]));
			check(32'(ledHand), 32'(c[6]));
			if (!c[8])
				check(32'(ledTune), 32'(c[7]));
			tg = 0;
			repeat (64) begin
				last = ledHalt;
				@(posedge clk);
				tg += int'(ledHalt !== last);
			end
			if (c[5])
				check(32'(tg >= 3), 32'h1);
			else
				check(32'(ledHalt === c[4] && tg == 0), 32'h1);
		end
		a = 16'($random(seed) & 32'h7FFF) + 16'h0010;
		wr(`FPOI_REG_CTRL, 32'h4);
		wr(`FPOI_REG_SETPOINT, {16'h0, a});
		press(3'b001, 30);
		rd(`FPOI_REG_SETPOINT, q);
		check(q, {16'h0, a + 16'h1});
		press(3'b010, 30);
		press(3'b010, 30);
		check(32'(lowerDisp), 32'(a - 16'h1));
		wr(`FPOI_REG_CTRL, 32'h0);
		for (int f = 0; f < 5; f++) begin
			fn = (f == 4) ? 2'h1 : f[1:0];
			a = 16'($random(seed));
			b = (f == 4) ? 16'h0 : 16'($random(seed));
			if (fn == 2'h1)
				a = a >> 8;
			wr(`FPOI_REG_PV1, {16'h0, a});
			wr(`FPOI_REG_PV2, {16'h0, b});
			wr(`FPOI_REG_SELECT, {27'h0, 1'b1, fn, 2'h2});
			repeat (40) @(posedge clk);
			rd(`FPOI_REG_FEED, q);
			check(q, {16'h0, calc_exp(fn, a, b)});
		end
		wr(`FPOI_REG_SELECT, 32'h11);
		rd(`FPOI_REG_FEED, q);
		check(q, {16'h0, b});
		wr(`FPOI_REG_SELECT, 32'h01);
		rd(`FPOI_REG_FEED, q);
		check(q, {16'h0, a});
		wr(`FPOI_REG_ACTIVITY, 32'h1);
		repeat (2) @(posedge clk);
		check(32'(ledLink), 32'h1);
		repeat (10) @(posedge clk);
		check(32'(ledLink), 32'h0);
		press(3'b100, 260);
		check({upperDisp, lowerDisp}, {`FPOI_MENU_CODE, 16'h0});
		press(3'b001, 30);
		check(32'(lowerDisp), 32'h1);
		press(3'b010, 30);
		press(3'b010, 30);
		check(32'(lowerDisp), 32'h6);
		press(3'b100, 140);
		rd(`FPOI_REG_STATUS, q);
		check(q & 32'hFF, 32'h19);
		press(3'b100, 40);
		check(32'(upperDisp), 32'hC060);
		press(3'b001, 30);
		check(32'(lowerDisp), 32'h1);
		press(3'b100, 40);
		rd(`FPOI_REG_STATUS, q);
		check({q[7:0], upperDisp}, {8'h3A, 16'hC061});
		wr(`FPOI_REG_PADDR, 32'd48);
		rd(`FPOI_REG_PDATA, q);
		check(q, 32'h1);
		press(3'b100, 260);
		rd(`FPOI_REG_STATUS, q);
		check(q & 32'h3, 32'h1);
		press(3'b100, 260);
		rd(`FPOI_REG_STATUS, q);
		check(q & 32'h3, 32'h0);
		final_report();
	end
endmodule
